// *** hdl/etp_fatal_seq.sv ***
// Fatal error sequencer: timed pulse or hold-until-reset on the error pin.
`default_nettype none

module etp_fatal_seq
  import etp_pkg::*;
(
  input wire logic  i_clk,   // Base clock.
  input wire logic  i_rst_n, // Internal synchronous reset, active low.
  etp_fatal_if.seq  fe       // Error events in, pin drive out.
);

  etp_fatal_st_t st_ff;
  etp_fatal_st_t nxt_st;
  logic [4:0]    cnt_ff;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  // An internal failure overrides a running pulse, and it also wins over a
  // warm reset in the same cycle so that the event is never lost.
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      FE_IDLE: begin
        if (fe.internal_failure_class_error) begin
          nxt_st = FE_HOLD;
        end else if (fe.machine_check_class_error) begin
          nxt_st = FE_PULSE;
        end
      end
      FE_PULSE: begin
        if (fe.internal_failure_class_error) begin
          nxt_st = FE_HOLD;
        end else if (cnt_ff == FATAL_CNT_LAST) begin
          nxt_st = FE_IDLE;
        end
      end
      FE_HOLD: begin
        if (fe.warm_reset && !fe.internal_failure_class_error) begin
          nxt_st = FE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= FE_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A machine check arriving during a pulse is merged into it.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= 5'h00;
    end else if (st_ff == FE_PULSE) begin
      cnt_ff <= cnt_ff + 5'h01;
    end else begin
      cnt_ff <= 5'h00;
    end
  end

  assign fe.drive = (st_ff != FE_IDLE);
  assign fe.hold  = (st_ff == FE_HOLD);

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sixteen_active;
    fe.drive[*8] ##1 fe.drive[*8];
  endsequence

  AST_FATAL_PULSE_LEN: assert property (
    (st_ff == FE_IDLE && fe.machine_check_class_error &&
     !fe.internal_failure_class_error)
    |=> s_sixteen_active ##1 (!fe.drive || fe.hold))
    else $error("Machine check pulse is not sixteen cycles long.");

  AST_FATAL_HOLD_SET: assert property (
    fe.internal_failure_class_error |=> fe.hold && fe.drive)
    else $error("Internal failure did not latch the error output.");

  AST_FATAL_HOLD_KEEP: assert property (
    fe.hold && !fe.warm_reset |=> fe.hold)
    else $error("Latched internal failure released without reset.");

endmodule : etp_fatal_seq

`default_nettype wire

// *** hdl/etp_sideband.sv ***
// Error, thermal and power-good sideband logic of the processor.
`default_nettype none

// What this block does
// - Pull the fatal error pin low on any unrecoverable machine check or internal error.
// - A machine-check-class error pulls the fatal error pin low for exactly 16 cycles.
// - An internal-failure-class error holds the fatal error pin low until warm or cold reset.
// - An outside agent pulling the fatal error pin low while the device is not driving it makes the device take a machine check.
// - Pull the thermal hot pin low while the sensor reports the maximum safe temperature.
// - An outside agent pulling the thermal hot pin low activates the throttle like a local overheat.
// - Assert the low-current status only while the worst-case core current is below 15 A.
// - Release the low-current status at least 3.3 us before current may exceed 15 A.
// - Each level of the low-current status stands for at least one base clock cycle.
// - Above the trip temperature, halt execution and assert the thermal shutdown output.
// - Raise the test port power-ok only when the test access port can be accessed.
module etp_sideband
  import etp_pkg::*;
(
  input  wire logic i_clk,                          // Base clock, 10 MHz.
  input  wire logic i_rst_n,                        // Cold reset, active low.
  input  wire logic i_core_supply_ok_0,             // Async core good 0.
  input  wire logic i_core_supply_ok_1,             // Async core good 1.
  input  wire logic i_io_supply_ok,                 // Async I/O good.
  input  wire logic i_warm_reset,                   // Warm reset pulse.
  input  wire logic i_machine_check_class_error,    // Internal MC event.
  input  wire logic i_internal_failure_class_error, // Internal fail event.
  input  wire logic i_fatal_error_n,                // Fatal pin level.
  output logic      o_fatal_error_n,                // Fatal pin drive value.
  output logic      o_fatal_error_oe,               // Fatal pin drive enable.
  output logic      o_machine_check_exception,      // Take machine check.
  input  wire logic i_temp_at_max,                  // Sensor at max temp.
  input  wire logic i_throttle_enable,              // Throttle unit enable.
  input  wire logic i_thermal_hot_n,                // Thermal hot pin level.
  output logic      o_thermal_hot_n,                // Hot pin drive value.
  output logic      o_thermal_hot_oe,               // Hot pin drive enable.
  output logic      o_throttle_active,              // Throttle unit on.
  input  wire logic i_max_current_low,              // Worst case below 15 A.
  input  wire logic i_current_raise_req,            // Wants to exceed 15 A.
  output logic      o_current_raise_grant,          // May now exceed 15 A.
  output logic      o_low_current_status_n,         // Low-current status.
  input  wire logic i_junction_over_trip,           // Above trip temp.
  output logic      o_thermal_shutdown_n,           // Thermal shutdown.
  output logic      o_halt_execution,               // Stop all execution.
  input  wire logic i_tap_ready,                    // Test port ready.
  output logic      o_test_port_power_ok            // Test port power-ok.
);

  // -----------------------------------------------------------------------
  // Supply-good synchronisers and internal reset
  // -----------------------------------------------------------------------
  // The platform is trusted to keep the supply inputs clean and ordered;
  // a violated order only shows as an early internal reset here.
  logic [2:0] sup_meta_ff;
  logic [2:0] sup_sync_ff;
  logic       supplies_ok;
  logic       rst_int_n;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sup_meta_ff <= SYNC_RST;
      sup_sync_ff <= SYNC_RST;
    end else begin
      sup_meta_ff <= {i_io_supply_ok, i_core_supply_ok_1,
                      i_core_supply_ok_0};
      sup_sync_ff <= sup_meta_ff;
    end
  end

  // Any supply dropping counts as a cold reset for the whole block.
  assign supplies_ok = &sup_sync_ff;
  assign rst_int_n   = i_rst_n && supplies_ok;

  // -----------------------------------------------------------------------
  // Fatal error pin
  // -----------------------------------------------------------------------
  etp_fatal_if fe_if ();
  logic        ext_fatal_prev_ff;
  logic        mce_exc_ff;
  logic        ext_fatal;

  assign fe_if.machine_check_class_error    = i_machine_check_class_error;
  assign fe_if.internal_failure_class_error =
    i_internal_failure_class_error;
  assign fe_if.warm_reset                   = i_warm_reset;

  etp_fatal_seq u_fatal_seq (
    .i_clk   (i_clk),
    .i_rst_n (rst_int_n),
    .fe      (fe_if.seq)
  );

  // Open drain: the value is always low, only the enable moves.
  assign o_fatal_error_n  = 1'b0;
  assign o_fatal_error_oe = fe_if.drive;

  // Our own drive is not mistaken for an outside agent.
  assign ext_fatal = !i_fatal_error_n && !fe_if.drive;

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      ext_fatal_prev_ff <= FLAG_RST;
      mce_exc_ff        <= FLAG_RST;
    end else begin
      ext_fatal_prev_ff <= ext_fatal;
      mce_exc_ff        <= ext_fatal && !ext_fatal_prev_ff;
    end
  end

  assign o_machine_check_exception = mce_exc_ff;

  // -----------------------------------------------------------------------
  // Thermal hot pin and throttle
  // -----------------------------------------------------------------------
  logic hot_drive_ff;
  logic throttle_ff;

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      hot_drive_ff <= FLAG_RST;
    end else begin
      hot_drive_ff <= i_temp_at_max;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      throttle_ff <= FLAG_RST;
    end else begin
      throttle_ff <= i_throttle_enable &&
                     (i_temp_at_max ||
                      (!i_thermal_hot_n && !hot_drive_ff));
    end
  end

  assign o_thermal_hot_n   = 1'b0;
  assign o_thermal_hot_oe  = hot_drive_ff;
  assign o_throttle_active = throttle_ff;

  // -----------------------------------------------------------------------
  // Low-current status
  // -----------------------------------------------------------------------
  // A raise always waits out the full lead time from the release, even if
  // the status was already released; simpler, at a cost of latency.
  etp_lowcur_st_t lc_st_ff;
  etp_lowcur_st_t nxt_lc_st;
  logic [5:0]     lc_cnt_ff;
  logic [1:0]     lc_hold_ff;
  logic           lc_out_n_ff;
  logic           nxt_lc_out_n;
  logic           lc_grant_ff;
  logic           lc_change_ok;

  assign lc_change_ok = (lc_hold_ff >= LOWCUR_MIN);

  always_comb begin
    nxt_lc_st = lc_st_ff;
    unique case (lc_st_ff)
      LC_IDLE: begin
        if (i_current_raise_req) begin
          nxt_lc_st = LC_WAIT;
        end
      end
      LC_WAIT: begin
        if (!i_current_raise_req) begin
          nxt_lc_st = LC_IDLE;
        end else if (lc_out_n_ff && lc_cnt_ff == RAISE_CNT_LAST) begin
          nxt_lc_st = LC_GRANT;
        end
      end
      LC_GRANT: begin
        if (!i_current_raise_req) begin
          nxt_lc_st = LC_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    nxt_lc_out_n = 1'b1;
    if (nxt_lc_st == LC_IDLE) begin
      nxt_lc_out_n = !i_max_current_low;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      lc_st_ff <= LC_IDLE;
    end else begin
      lc_st_ff <= nxt_lc_st;
    end
  end

  // The lead count runs only once the release is really on the pin.
  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      lc_cnt_ff <= 6'h00;
    end else if (lc_st_ff == LC_WAIT && lc_out_n_ff) begin
      lc_cnt_ff <= lc_cnt_ff + 6'h01;
    end else begin
      lc_cnt_ff <= 6'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      lc_out_n_ff <= LOWCUR_OUT_N_RST;
      lc_hold_ff  <= LOWCUR_MIN;
    end else if (lc_change_ok && nxt_lc_out_n != lc_out_n_ff) begin
      lc_out_n_ff <= nxt_lc_out_n;
      lc_hold_ff  <= 2'h1;
    end else if (lc_hold_ff != LOWCUR_HOLD_MAX) begin
      lc_hold_ff  <= lc_hold_ff + 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      lc_grant_ff <= FLAG_RST;
    end else begin
      lc_grant_ff <= (nxt_lc_st == LC_GRANT);
    end
  end

  assign o_low_current_status_n = lc_out_n_ff;
  assign o_current_raise_grant  = lc_grant_ff;

  // -----------------------------------------------------------------------
  // Thermal trip and test port power-ok
  // -----------------------------------------------------------------------
  // The trip stays latched until a cold reset or a supply drop.
  logic trip_ff;
  logic tap_ok_ff;

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      trip_ff <= FLAG_RST;
    end else begin
      trip_ff <= trip_ff || i_junction_over_trip;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!rst_int_n) begin
      tap_ok_ff <= FLAG_RST;
    end else begin
      tap_ok_ff <= i_tap_ready;
    end
  end

  assign o_thermal_shutdown_n = !trip_ff;
  assign o_halt_execution     = trip_ff;
  assign o_test_port_power_ok = tap_ok_ff;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  logic [5:0] lc_high_run_ff;

  always_ff @(posedge i_clk) begin
    if (!rst_int_n || !lc_out_n_ff) begin
      lc_high_run_ff <= 6'h00;
    end else if (lc_high_run_ff != RAISE_RUN_MAX) begin
      lc_high_run_ff <= lc_high_run_ff + 6'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_int_n);

  AST_EXT_FATAL_MCE: assert property (
    ext_fatal && !$past(ext_fatal) |=> o_machine_check_exception)
    else $error("Outside fatal assertion gave no machine check.");

  AST_THROTTLE_ON: assert property (
    i_throttle_enable && !i_thermal_hot_n && !o_thermal_hot_oe
    |=> o_throttle_active)
    else $error("Outside thermal hot did not throttle.");

  AST_HOT_DRIVE: assert property (
    i_temp_at_max |=> o_thermal_hot_oe)
    else $error("Thermal hot pin not driven at max temperature.");

  AST_LOWCUR_ONLY_LOW: assert property (
    $fell(o_low_current_status_n) |-> $past(i_max_current_low))
    else $error("Low-current status asserted above threshold.");

  AST_RAISE_LEAD: assert property (
    o_current_raise_grant |-> o_low_current_status_n &&
    lc_high_run_ff >= 6'(RAISE_LEAD_CYCLES))
    else $error("Raise granted before the release lead time.");

  AST_LOWCUR_MIN: assert property (
    $changed(o_low_current_status_n) |=> $stable(o_low_current_status_n)
    or lc_hold_ff >= LOWCUR_MIN)
    else $error("Low-current status level stood too short.");

  AST_TRIP_LATCH: assert property (
    i_junction_over_trip |=> !o_thermal_shutdown_n [*2])
    else $error("Thermal shutdown not asserted and held.");

  AST_TAP_READY: assert property (
    o_test_port_power_ok |-> $past(i_tap_ready))
    else $error("Test port power-ok without port ready.");

endmodule : etp_sideband

`default_nettype wire

// *** shared/etp_fatal_if.sv ***
// Carrier between the sideband top and the fatal error sequencer.
`default_nettype none

interface etp_fatal_if;
  logic machine_check_class_error;     // One-cycle event.
  logic internal_failure_class_error;  // One-cycle event.
  logic warm_reset;                    // One-cycle warm reset request.
  logic drive;                         // High while the pin is pulled low.
  logic hold;                          // High while latched until reset.

  modport ctrl (
    output machine_check_class_error,
    output internal_failure_class_error,
    output warm_reset,
    input  drive,
    input  hold
  );

  modport seq (
    input  machine_check_class_error,
    input  internal_failure_class_error,
    input  warm_reset,
    output drive,
    output hold
  );
endinterface : etp_fatal_if

`default_nettype wire

// *** shared/etp_pkg.sv ***
// Constants, state encodings and timing for the error and thermal sideband.
`default_nettype none

package etp_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 100;
  // Fatal error pulse length for a machine-check-class error, in cycles.
  localparam int unsigned FATAL_PULSE_CYCLES = 16;
  localparam logic [4:0]  FATAL_CNT_LAST     = 5'(FATAL_PULSE_CYCLES - 1);
  // Lead time of the low-current release before current may rise (3.3 us).
  localparam int unsigned RAISE_LEAD_NS      = 3300;
  localparam int unsigned RAISE_LEAD_CYCLES  =
    (RAISE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  RAISE_CNT_LAST     = 6'(RAISE_LEAD_CYCLES - 1);
  localparam logic [5:0]  RAISE_RUN_MAX      = 6'h3f;
  // Least time each low-current level stands, in base clock cycles.
  localparam int unsigned LOWCUR_MIN_CYCLES  = 1;
  localparam logic [1:0]  LOWCUR_MIN         = 2'(LOWCUR_MIN_CYCLES);
  localparam logic [1:0]  LOWCUR_HOLD_MAX    = 2'h3;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [2:0]  SYNC_RST           = 3'h0;
  localparam logic        LOWCUR_OUT_N_RST   = 1'b1;
  localparam logic        FLAG_RST           = 1'b0;

  // ---------------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    FE_IDLE  = 3'b001,
    FE_PULSE = 3'b010,
    FE_HOLD  = 3'b100
  } etp_fatal_st_t;

  typedef enum logic [2:0] {
    LC_IDLE  = 3'b001,
    LC_WAIT  = 3'b010,
    LC_GRANT = 3'b100
  } etp_lowcur_st_t;

endpackage : etp_pkg

`default_nettype wire

// *** verification/etp_platform_model.sv ***
// Platform model: supply-good sequencing and pulled-up open-drain pins.
`default_nettype none

module etp_platform_model (
  input  wire logic i_clk,       // Base clock.
  input  wire logic i_power_on,  // Bench asks for power up.
  input  wire logic i_ext_fatal, // Outside agent pulls fatal pin.
  input  wire logic i_ext_hot,   // Outside agent pulls hot pin.
  input  wire logic i_fatal_val, // Device fatal drive value.
  input  wire logic i_fatal_oe,  // Device fatal drive enable.
  input  wire logic i_hot_val,   // Device hot drive value.
  input  wire logic i_hot_oe,    // Device hot drive enable.
  output logic      o_io_ok,     // I/O supply good.
  output logic      o_core_ok_0, // Core supply good 0.
  output logic      o_core_ok_1, // Core supply good 1.
  output logic      o_fatal_pin, // Resolved fatal pin level.
  output logic      o_hot_pin    // Resolved hot pin level.
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] ramp_ff;

  // ---------------------------------------------------------------------
  // Supply ramp
  // ---------------------------------------------------------------------
  // One ramp keeps every edge monotonic and glitch-free, and the
  // thresholds order I/O good before core good on the way up and after
  // it on the way down.
  // The ramp moves on the rising edge, away from the falling edge on which
  // the bench changes its request, so that the two never race.
  initial ramp_ff = 4'h0;
  always @(posedge i_clk) begin
    if (i_power_on && ramp_ff != 4'h8) begin
      ramp_ff <= ramp_ff + 4'h1;
    end else if (!i_power_on && ramp_ff != 4'h0) begin
      ramp_ff <= ramp_ff - 4'h1;
    end
  end

  assign o_io_ok     = (ramp_ff >= 4'h2);
  assign o_core_ok_0 = (ramp_ff >= 4'h6);
  assign o_core_ok_1 = (ramp_ff >= 4'h6);

  // Both pins have pull-ups; any party driving low wins.
  assign o_fatal_pin = !((i_fatal_oe && !i_fatal_val) || i_ext_fatal);
  assign o_hot_pin   = !((i_hot_oe && !i_hot_val) || i_ext_hot);
endmodule : etp_platform_model

`default_nettype wire

// *** verification/etp_sideband_bench.sv ***
// Self-checking bench for the error, thermal and power-good sideband.
`default_nettype none

module etp_sideband_bench
  import etp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_clk, i_rst_n, power_on, ext_fatal, ext_hot, warm, mc_err;
  logic fail_err, temp_max, thr_en, max_low, raise_req, over_trip, tap_rdy;
  wire  io_ok, core0, core1, fatal_pin, hot_pin, fe_val, fe_oe, mce;
  wire  hot_val, hot_oe, throttle, grant, lc_n, shut_n, halt, tap_ok;
  int   num_errors, samples_checked;

  etp_sideband etp_sideband_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_core_supply_ok_0(core0),
    .i_core_supply_ok_1(core1), .i_io_supply_ok(io_ok),
    .i_warm_reset(warm), .i_machine_check_class_error(mc_err),
    .i_internal_failure_class_error(fail_err),
    .i_fatal_error_n(fatal_pin), .o_fatal_error_n(fe_val),
    .o_fatal_error_oe(fe_oe), .o_machine_check_exception(mce),
    .i_temp_at_max(temp_max), .i_throttle_enable(thr_en),
    .i_thermal_hot_n(hot_pin), .o_thermal_hot_n(hot_val),
    .o_thermal_hot_oe(hot_oe), .o_throttle_active(throttle),
    .i_max_current_low(max_low), .i_current_raise_req(raise_req),
    .o_current_raise_grant(grant), .o_low_current_status_n(lc_n),
    .i_junction_over_trip(over_trip), .o_thermal_shutdown_n(shut_n),
    .o_halt_execution(halt), .i_tap_ready(tap_rdy),
    .o_test_port_power_ok(tap_ok));

  etp_platform_model etp_platform_model_i (
    .i_clk(i_clk), .i_power_on(power_on), .i_ext_fatal(ext_fatal),
    .i_ext_hot(ext_hot), .i_fatal_val(fe_val), .i_fatal_oe(fe_oe),
    .i_hot_val(hot_val), .i_hot_oe(hot_oe), .o_io_ok(io_ok),
    .o_core_ok_0(core0), .o_core_ok_1(core1), .o_fatal_pin(fatal_pin),
    .o_hot_pin(hot_pin));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick

  task automatic check(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_fatal_pulse();
    mc_err = 1'b1;
    tick(1);
    mc_err = 1'b0;
    for (int i = 0; i < FATAL_PULSE_CYCLES; i++) begin
      check(fe_oe, 1'b1, "mc pulse short");
      check(fatal_pin, 1'b0, "fatal pin high");
      check(mce, 1'b0, "own pulse seen as outside");
      tick(1);
    end
    check(fe_oe, 1'b0, "mc pulse long");
  endtask : t_fatal_pulse

  task automatic t_fatal_hold();
    mc_err = 1'b1;
    tick(1);
    mc_err = 1'b0;
    tick(3);
    fail_err = 1'b1;
    tick(1);
    fail_err = 1'b0;
    repeat (20) begin
      check(fe_oe, 1'b1, "failure hold dropped");
      tick(1);
    end
    warm = 1'b1;
    tick(1);
    warm = 1'b0;
    check(fe_oe, 1'b0, "warm reset kept hold");
    fail_err = 1'b1;
    tick(1);
    warm = 1'b1;
    tick(1);
    fail_err = 1'b0;
    warm = 1'b0;
    tick(1);
    check(fe_oe, 1'b1, "failure lost to warm reset");
  endtask : t_fatal_hold

  task automatic t_trip_and_cold();
    over_trip = 1'b1;
    tick(1);
    over_trip = 1'b0;
    check(shut_n, 1'b0, "no shutdown");
    check(halt, 1'b1, "no halt");
    warm = 1'b1;
    tick(1);
    warm = 1'b0;
    tick(2);
    check(shut_n, 1'b0, "shutdown not latched");
    fail_err = 1'b1;
    tick(1);
    fail_err = 1'b0;
    check(fe_oe, 1'b1, "hold not set before power drop");
    power_on = 1'b0;
    tick(8);
    check(fe_oe, 1'b0, "hold kept in cold reset");
    check(shut_n, 1'b1, "shutdown in supply reset");
    check(halt, 1'b0, "halt in supply reset");
    power_on = 1'b1;
    tick(14);
    check(fatal_pin, 1'b1, "fatal pin after cold reset");
  endtask : t_trip_and_cold

  task automatic t_ext_fatal();
    ext_fatal = 1'b1;
    tick(1);
    check(mce, 1'b1, "no machine check");
    tick(1);
    check(mce, 1'b0, "machine check too wide");
    ext_fatal = 1'b0;
    tick(1);
  endtask : t_ext_fatal

  task automatic t_thermal();
    thr_en = 1'b1;
    temp_max = 1'b1;
    tick(1);
    check(hot_oe, 1'b1, "hot not driven");
    check(hot_pin, 1'b0, "hot pin high");
    check(throttle, 1'b1, "no throttle");
    thr_en = 1'b0;
    tick(1);
    check(throttle, 1'b0, "throttle while disabled");
    temp_max = 1'b0;
    thr_en = 1'b1;
    tick(2);
    check(hot_oe, 1'b0, "hot still driven");
    ext_hot = 1'b1;
    tick(1);
    check(throttle, 1'b1, "outside hot ignored");
    check(hot_oe, 1'b0, "outside hot echoed");
    ext_hot = 1'b0;
    tick(1);
    check(throttle, 1'b0, "throttle stuck");
  endtask : t_thermal

  task automatic t_low_current();
    max_low = 1'b0;
    tick(1);
    check(lc_n, 1'b1, "status with high current");
    max_low = 1'b1;
    tick(1);
    check(lc_n, 1'b0, "no low-current status");
    raise_req = 1'b1;
    tick(1);
    check(grant, 1'b0, "early grant");
    for (int i = 1; i <= RAISE_LEAD_CYCLES; i++) begin
      tick(1);
      check(lc_n, 1'b1, "status during raise");
      check(grant, i == RAISE_LEAD_CYCLES, "grant lead time");
    end
    raise_req = 1'b0;
    tick(1);
    check(grant, 1'b0, "grant kept");
    tick(2);
    check(lc_n, 1'b0, "status not restored");
    raise_req = 1'b1;
    tick(1);
    raise_req = 1'b0;
    check(lc_n, 1'b1, "aborted raise level");
    tick(3);
    check(grant, 1'b0, "grant after abort");
  endtask : t_low_current

  task automatic t_tap();
    tap_rdy = 1'b1;
    tick(1);
    check(tap_ok, 1'b1, "tap not ready");
    tap_rdy = 1'b0;
    tick(1);
    check(tap_ok, 1'b0, "tap ready stuck");
  endtask : t_tap

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    {i_rst_n, ext_fatal, ext_hot, warm, mc_err, fail_err} = 6'h00;
    {thr_en, max_low, raise_req, over_trip} = 4'h0;
    {power_on, temp_max, tap_rdy} = 3'h7;
    num_errors = 0;
    samples_checked = 0;
    tick(20);
    check(hot_oe, 1'b0, "hot driven in reset");
    check(tap_ok, 1'b0, "tap ready in reset");
    check(lc_n, 1'b1, "status in reset");
    {i_rst_n, temp_max, tap_rdy} = 3'h4;
    tick(4);
    t_fatal_pulse();
    t_ext_fatal();
    t_fatal_hold();
    t_trip_and_cold();
    t_thermal();
    t_low_current();
    t_tap();
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    $display("FAIL %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : etp_sideband_bench

`default_nettype wire
